// *** hw/mts_trig_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module mts_trig_seq
    import mts_pkg::*;
#(
    parameter int SETUP_CYCLES = SETUP_CYC      // shorten in simulation
) (
    input  wire logic     clk_i,                // 125 MHz instrument clock
    input  wire logic     nrst_i,               // async low reset, power/remote
    input  wire mts_bus_t bus_i,                // register port request
    output logic [31:0]   rdata_o,              // read data, cycle after strobe
    input  wire logic     remote_i,             // 1 = under remote control
    input  wire logic     key_single_i,         // front-panel key press pulse
    input  wire logic     get_i,                // group execute trigger pulse
    input  wire logic     ext_trig_n_i,         // external trigger pin, low true
    input  wire mts_rdg_t rdg_i,                // converter reading finished
    output logic          start_o,              // start one conversion, pulse
    output logic          meas_complete_n_o,    // measurement_complete_output
    output logic          pass_n_o,             // limit pass pulse, low
    output logic          fail_n_o,             // limit fail pulse, low
    output logic          wait_lamp_o,          // waiting-for-trigger indicator
    output logic          sample_lamp_o         // sampling indicator
);

    // ------------------------------------------------------------------------
    // all state in one struct
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  rst_sync;     // reset release pipe
        logic [1:0]  ext_sync;     // two-stage pin synchroniser
        logic        ext_last;     // previous synchronised level
        mts_src_t    src;          // trigger source
        logic        lim_en;       // limit outputs enabled
        logic [15:0] scount;       // samples per trigger
        logic [15:0] tcount;       // triggers per arming
        logic [31:0] delay;        // delay before each reading
        logic [31:0] lower;        // lower limit
        logic [31:0] upper;        // upper limit
        mts_state_t  st;           // sequencer state
        logic [31:0] tmr;          // set-up and delay timer
        logic [15:0] s_done;       // samples taken in burst
        logic [15:0] t_done;       // triggers taken since arming
        logic        ext_pend;     // buffered external trigger
        logic [7:0]  pw_cnt;       // output pulse width counter
        logic        pass_p;       // pass pulse active
        logic        fail_p;       // fail pulse active
        logic        cmpl_p;       // complete pulse active
        logic        start;        // conversion start
        logic [31:0] rdata;        // read data register
    } mts_state_s_t;

    mts_state_s_t r;              // registered state
    mts_state_s_t next_r;         // next state
    logic         rst_n;          // synchronised reset

    assign rst_n = r.rst_sync[1];

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    logic ext_fall;     // synchronised falling edge
    logic trig_now;     // a trigger is present this cycle
    logic arming;       // arm command strobe
    logic conf;         // configure command strobe
    logic dclr;         // device clear strobe
    logic bus_trg;      // bus trigger strobe
    logic cmd_wr;       // write to the command register
    logic in_lim;       // reading lies inside the limits

    always_comb begin
        // only the second stage is read by logic
        ext_fall = r.ext_last & ~r.ext_sync[1];
        cmd_wr   = bus_i.wr && (bus_i.addr == ADDR_CMD);
        arming   = cmd_wr & bus_i.wdata[CMD_ARM];
        conf     = cmd_wr & bus_i.wdata[CMD_CONF];
        dclr     = cmd_wr & bus_i.wdata[CMD_DCLR];
        bus_trg  = (cmd_wr & bus_i.wdata[CMD_BUS]) | get_i;
        in_lim   = ($signed(rdg_i.value) >= $signed(r.lower)) &&
                   ($signed(rdg_i.value) <= $signed(r.upper));
        // remote takes the selected source only; local takes auto, else external, plus the key in single
        if (remote_i) begin
            case (r.src)
                MTS_SRC_IMM: trig_now = 1'b1;
                MTS_SRC_BUS: trig_now = bus_trg;
                MTS_SRC_EXT: trig_now = r.ext_pend;
                default:     trig_now = 1'b1;
            endcase
        end else begin
            case (r.src)
                MTS_SRC_AUTO: trig_now = 1'b1;
                // single mode takes the key and the external pin
                MTS_SRC_EXT:  trig_now = key_single_i | r.ext_pend;
                default:      trig_now = r.ext_pend;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        next_r          = r;
        next_r.rst_sync = {r.rst_sync[0], 1'b1};
        next_r.ext_sync = {r.ext_sync[0], ext_trig_n_i};
        next_r.ext_last = r.ext_sync[1];
        next_r.start    = 1'b0;

        // register writes
        if (bus_i.wr) begin
            case (bus_i.addr)
                ADDR_CTRL: begin
                    next_r.src    = mts_src_t'(bus_i.wdata[CTRL_SRC_LSB +: 2]);
                    next_r.lim_en = bus_i.wdata[CTRL_LIM_EN];
                end
                ADDR_SCOUNT: begin
                    // out-of-range values clamp into 1..50000
                    if (bus_i.wdata[15:0] == 16'h0000)
                        next_r.scount = COUNT_DEF;
                    else if (bus_i.wdata[15:0] > COUNT_MAX)
                        next_r.scount = COUNT_MAX;
                    else
                        next_r.scount = bus_i.wdata[15:0];
                end
                ADDR_TCOUNT: begin
                    if (bus_i.wdata[15:0] == 16'h0000)
                        next_r.tcount = COUNT_DEF;
                    else if (bus_i.wdata[15:0] > COUNT_MAX)
                        next_r.tcount = COUNT_MAX;
                    else
                        next_r.tcount = bus_i.wdata[15:0];
                end
                ADDR_DELAY: next_r.delay = bus_i.wdata;
                ADDR_LOWER: next_r.lower = bus_i.wdata;
                ADDR_UPPER: next_r.upper = bus_i.wdata;
                default: ;
            endcase
        end
        // configure restores the per-measurement defaults
        if (conf) begin
            next_r.scount = COUNT_DEF;
            next_r.tcount = COUNT_DEF;
            next_r.src    = MTS_SRC_IMM;
        end

        // read data, valid the cycle after the strobe
        next_r.rdata = 32'h0000_0000;
        if (bus_i.rd) begin
            case (bus_i.addr)
                ADDR_CTRL:   next_r.rdata = {29'h0, r.lim_en, r.src};
                ADDR_SCOUNT: next_r.rdata = {16'h0, r.scount};
                ADDR_TCOUNT: next_r.rdata = {16'h0, r.tcount};
                ADDR_DELAY:  next_r.rdata = r.delay;
                ADDR_STAT:   next_r.rdata = {r.t_done, 11'h0, r.ext_pend, 1'b0, r.st};
                ADDR_LOWER:  next_r.rdata = r.lower;
                ADDR_UPPER:  next_r.rdata = r.upper;
                default:     next_r.rdata = 32'h0000_0000;
            endcase
        end

        // buffer one external pulse, discarded during set-up
        if (ext_fall && (r.st != MTS_SETUP) && (r.st != MTS_IDLE || !remote_i))
            next_r.ext_pend = 1'b1;

        // sequencer
        case (r.st)
            MTS_IDLE: begin
                next_r.t_done = 16'h0000;
                // local operation never needs arming
                if (!remote_i) begin
                    next_r.st = MTS_WAIT;
                end else if (arming) begin
                    next_r.st  = MTS_SETUP;
                    next_r.tmr = 32'(SETUP_CYCLES);
                end
            end
            MTS_SETUP: begin
                next_r.ext_pend = 1'b0;
                if (r.tmr <= 32'h0000_0001)
                    next_r.st = MTS_WAIT;
                else
                    next_r.tmr = r.tmr - 32'h0000_0001;
            end
            MTS_WAIT: begin
                // triggers only count in this state
                if (trig_now) begin
                    next_r.ext_pend = 1'b0;
                    next_r.s_done   = 16'h0000;
                    next_r.st       = MTS_DELAY;
                    next_r.tmr      = r.delay;
                end
            end
            MTS_DELAY: begin
                if (r.tmr == 32'h0000_0000) begin
                    next_r.start = 1'b1;
                    next_r.st    = MTS_MEAS;
                end else begin
                    next_r.tmr = r.tmr - 32'h0000_0001;
                end
            end
            MTS_MEAS: begin
                if (rdg_i.done) begin
                    next_r.cmpl_p = 1'b1;
                    next_r.pw_cnt = 8'(PULSE_CYC);
                    next_r.pass_p = r.lim_en & in_lim;
                    next_r.fail_p = r.lim_en & ~in_lim;
                    if (r.s_done + 16'h0001 < r.scount) begin
                        next_r.s_done = r.s_done + 16'h0001;
                        next_r.tmr    = r.delay;
                        next_r.st     = MTS_DELAY;
                    end else if (!remote_i) begin
                        next_r.st = MTS_WAIT;
                    end else if (r.t_done + 16'h0001 < r.tcount) begin
                        next_r.t_done = r.t_done + 16'h0001;
                        next_r.st     = MTS_WAIT;
                    end else begin
                        next_r.st = MTS_IDLE;
                    end
                end
            end
            default: next_r.st = MTS_IDLE;
        endcase

        // output pulse width
        if (r.pw_cnt != 8'h00 && !(r.st == MTS_MEAS && rdg_i.done)) begin
            next_r.pw_cnt = r.pw_cnt - 8'h01;
            if (r.pw_cnt == 8'h01) begin
                next_r.cmpl_p = 1'b0;
                next_r.pass_p = 1'b0;
                next_r.fail_p = 1'b0;
            end
        end

        // device clear wins, settings stay put
        if (dclr) begin
            next_r.st       = MTS_IDLE;
            next_r.ext_pend = 1'b0;
            next_r.start    = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // state register; reset release pipe is separate from the logic reset
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r          <= '0;
            r.ext_sync <= 2'b11;
            r.ext_last <= 1'b1;
            r.src      <= MTS_SRC_AUTO;
            r.scount   <= COUNT_DEF;
            r.tcount   <= COUNT_DEF;
            r.delay    <= DELAY_DEF;
            r.lower    <= LIMIT_DEF;
            r.upper    <= LIMIT_DEF;
            r.st       <= MTS_IDLE;
        end else if (!rst_n) begin
            // hold logic in reset until release has passed two flops
            r.rst_sync <= next_r.rst_sync;
            r.ext_sync <= next_r.ext_sync;
            r.ext_last <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // source default depends on control mode: auto locally, immediate remotely
    // the remote view maps auto onto immediate in the trigger decode

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign rdata_o           = r.rdata;
    assign start_o           = r.start;
    assign meas_complete_n_o = ~r.cmpl_p;
    assign pass_n_o          = ~r.pass_p;
    assign fail_n_o          = ~r.fail_p;
    assign wait_lamp_o       = (r.st == MTS_WAIT);
    assign sample_lamp_o     = (r.st == MTS_DELAY) || (r.st == MTS_MEAS);

endmodule : mts_trig_seq
`default_nettype wire

// *** hw/mts_pkg.sv ***
// ----------------------------------------------------------------------------
// Notes on behaviour
// - pass pulse for in-limit reading
// - fail pulse for out-of-limit reading
// - sample count 1 to 50000, default 1
// - sample count back to one on configure
// - remote accepts only the selected source
// - reset source: auto local, immediate remote
// - configure forces immediate source
// - auto mode measures back to back
// - manual key starts burst, waiting lamp lit
// - manual key ignored under remote
// - one burst per external low pulse
// - buffer one external trigger during reading
// - local single mode also takes external
// - immediate source triggers on entering wait
// - bus command taken only while waiting
// - group execute trigger acts as bus command
// - triggers only in wait, sampling lamp
// - local always waiting unless measuring
// - 20 ms set-up, external pulses discarded
// - device clear aborts to idle
// - device clear keeps settings
// - trigger count 1 to 50000, remote only
// - delay before every reading of burst
// - complete pulse after each measurement
// ----------------------------------------------------------------------------
package mts_pkg;

    // ------------------------------------------------------------------------
    // register map, word addresses on the plain port
    // ------------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0; // source, limit enable
    localparam logic [3:0] ADDR_SCOUNT = 4'h1; // samples per trigger
    localparam logic [3:0] ADDR_TCOUNT = 4'h2; // triggers per arming
    localparam logic [3:0] ADDR_DELAY  = 4'h3; // delay in clock cycles
    localparam logic [3:0] ADDR_CMD    = 4'h4; // write-only command strobes
    localparam logic [3:0] ADDR_STAT   = 4'h5; // sequencer status
    localparam logic [3:0] ADDR_LOWER  = 4'h6; // lower limit
    localparam logic [3:0] ADDR_UPPER  = 4'h7; // upper limit

    // ctrl fields
    localparam int CTRL_SRC_LSB = 0;  // two-bit source
    localparam int CTRL_LIM_EN  = 2;  // limit pulse outputs enable
    // command bits
    localparam int CMD_ARM  = 0;      // measure, read or initiate
    localparam int CMD_CONF = 1;      // configure or measure
    localparam int CMD_BUS  = 2;      // bus trigger command
    localparam int CMD_DCLR = 3;      // device clear

    // ------------------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------------------
    localparam logic [15:0] COUNT_DEF   = 16'h0001;
    localparam logic [15:0] COUNT_MAX   = 16'hC350; // 50000
    localparam logic [31:0] DELAY_DEF   = 32'h0000_0000;
    localparam logic [31:0] LIMIT_DEF   = 32'h0000_0000;

    // ------------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------------
    localparam int CLK_MHZ        = 125;
    localparam int SETUP_MS       = 20;
    localparam int SETUP_CYC      = SETUP_MS * 1000 * CLK_MHZ; // 2.5M cycles
    localparam int PULSE_NS       = 80;
    localparam int PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;

    // trigger sources
    typedef enum logic [1:0] {
        MTS_SRC_AUTO = 2'b00,  // local continuous
        MTS_SRC_IMM  = 2'b01,  // remote immediate
        MTS_SRC_BUS  = 2'b10,  // remote bus command
        MTS_SRC_EXT  = 2'b11   // external / local single
    } mts_src_t;

    // sequencer states
    typedef enum logic [2:0] {
        MTS_IDLE  = 3'b000,
        MTS_SETUP = 3'b001,
        MTS_WAIT  = 3'b010,
        MTS_DELAY = 3'b011,
        MTS_MEAS  = 3'b100
    } mts_state_t;

    // register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } mts_bus_t;

    // one finished reading from the converter
    typedef struct packed {
        logic        done;
        logic [31:0] value;
    } mts_rdg_t;

endpackage : mts_pkg

// *** verif/mts_trig_seq_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------
// port checks of the trigger sequencer
// ----------------
module mts_trig_seq_properties
    import mts_pkg::*;
(
    input wire logic        clk_i,             // instrument clock
    input wire logic        nrst_i,            // async reset, low
    input wire mts_bus_t    bus_i,             // register port request
    input wire logic [31:0] rdata_o,           // read data
    input wire logic        remote_i,          // remote control level
    input wire logic        key_single_i,      // key press pulse
    input wire logic        get_i,             // group execute trigger
    input wire logic        ext_trig_n_i,      // external trigger pin
    input wire mts_rdg_t    rdg_i,             // finished reading
    input wire logic        start_o,           // conversion start
    input wire logic        meas_complete_n_o, // complete pulse, low
    input wire logic        pass_n_o,          // pass pulse, low
    input wire logic        fail_n_o,          // fail pulse, low
    input wire logic        wait_lamp_o,       // waiting lamp
    input wire logic        sample_lamp_o      // sampling lamp
);
    logic dclr_w; // device clear written this cycle
    assign dclr_w = bus_i.wr && (bus_i.addr == ADDR_CMD) && bus_i.wdata[CMD_DCLR];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_start_one_cycle: assert property (start_o |=> !start_o)
        else $error("start pulse longer than one cycle");
    a_start_sampling: assert property (start_o |-> sample_lamp_o)
        else $error("start outside the sampling state");
    a_lamps_apart: assert property (!(wait_lamp_o && sample_lamp_o))
        else $error("wait and sampling lamps lit together");
    // leaving wait under steady remote control without a device clear only ever goes to a measurement
    a_wait_exit: assert property (
        $fell(wait_lamp_o) && remote_i && $past(remote_i) && !$past(dclr_w) |-> sample_lamp_o)
        else $error("wait left without starting a measurement");
    a_clear_idle: assert property (dclr_w |=> !wait_lamp_o && !sample_lamp_o)
        else $error("device clear did not return to idle");
    a_pass_cause: assert property (
        $fell(pass_n_o) |-> $past(rdg_i.done) || $past(rdg_i.done, 2) || $past(rdg_i.done, 3))
        else $error("pass pulse without a reading");
    a_fail_cause: assert property (
        $fell(fail_n_o) |-> $past(rdg_i.done) || $past(rdg_i.done, 2) || $past(rdg_i.done, 3))
        else $error("fail pulse without a reading");
    a_pass_fail_apart: assert property (pass_n_o || fail_n_o)
        else $error("pass and fail pulses together");
    // the complete pulse is ten cycles, so a short or stuck pulse shows here
    a_complete_width: assert property (
        $fell(meas_complete_n_o) |-> !meas_complete_n_o [*8] ##1 !meas_complete_n_o
        ##1 !meas_complete_n_o ##1 meas_complete_n_o)
        else $error("complete pulse width wrong");

    c_start: cover property (start_o);
    c_pass: cover property ($fell(pass_n_o));
    c_fail: cover property ($fell(fail_n_o));
    c_clear: cover property (dclr_w && sample_lamp_o);
endmodule // mts_trig_seq_properties

bind mts_trig_seq mts_trig_seq_properties mts_trig_seq_properties_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata_o), .remote_i(remote_i),
    .key_single_i(key_single_i), .get_i(get_i), .ext_trig_n_i(ext_trig_n_i),
    .rdg_i(rdg_i), .start_o(start_o), .meas_complete_n_o(meas_complete_n_o),
    .pass_n_o(pass_n_o), .fail_n_o(fail_n_o), .wait_lamp_o(wait_lamp_o),
    .sample_lamp_o(sample_lamp_o));
`default_nettype wire

// *** verif/mts_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------
// converter and external switch model
// ----------------
module mts_conv_model
    import mts_pkg::*;
#(
    parameter int LAT = 12                   // cycles from start to reading
) (
    input  wire logic        clk_i,          // instrument clock
    input  wire logic        start_i,        // conversion start
    input  wire logic [31:0] val_i,          // value of the next reading
    input  wire logic        fire_i,         // bench asks for a trigger pulse
    output mts_rdg_t         rdg_o,          // finished reading
    output logic             ext_trig_n_o    // pin to the device, pulled up
);
    int cnt = 0; // conversion countdown
    int low = 0; // trigger pulse countdown
    initial rdg_o = '0;
    // value bus toggles outside done so a stale value never looks valid
    always @(posedge clk_i) begin
        rdg_o.done <= 1'b0;
        rdg_o.value <= ~rdg_o.value;
        if (start_i) begin
            cnt <= LAT;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        if (cnt == 1) begin
            rdg_o <= {1'b1, val_i};
        end
        low <= fire_i ? 3 : (low > 0 ? low - 1 : 0);
    end
    assign ext_trig_n_o = (low == 0);
endmodule // mts_conv_model
`default_nettype wire

// *** verif/mts_trig_seq_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------
// scenario bench
// ----------------
module mts_trig_seq_tb_top
    import mts_pkg::*;
;
    logic clk_i = 0, nrst_i = 0, remote_i = 1, key = 0, get = 0, fire = 0;
    mts_bus_t bus = '0;                  // register port request
    logic [31:0] val = 32'h0000_0032;    // next reading value
    logic [31:0] rdata;
    logic start, mc_n, pass_n, fail_n, wl, sl, ext_n;
    mts_rdg_t rdg;
    logic [31:0] n_st = 0, n_ps = 0, n_fl = 0, n_mc = 0; // event counts
    logic [31:0] b_st, b_ps, b_fl, b_mc;                 // counts at mark
    logic pp = 1, fp = 1, mp = 1;                        // last pulse levels
    int failures = 0, cmp_count = 0;

    always #4 clk_i = ~clk_i;
    mts_trig_seq #(.SETUP_CYCLES(20)) mts_trig_seq_i (.clk_i(clk_i), .nrst_i(nrst_i),
        .bus_i(bus), .rdata_o(rdata), .remote_i(remote_i), .key_single_i(key), .get_i(get),
        .ext_trig_n_i(ext_n), .rdg_i(rdg), .start_o(start), .meas_complete_n_o(mc_n),
        .pass_n_o(pass_n), .fail_n_o(fail_n), .wait_lamp_o(wl), .sample_lamp_o(sl));
    mts_conv_model mts_conv_model_i (.clk_i(clk_i), .start_i(start), .val_i(val),
        .fire_i(fire), .rdg_o(rdg), .ext_trig_n_o(ext_n));

    // counts starts and falling edges of the three low pulses
    always @(posedge clk_i) begin
        n_st <= n_st + {31'h0, start};
        n_ps <= n_ps + {31'h0, pp & ~pass_n};
        n_fl <= n_fl + {31'h0, fp & ~fail_n};
        n_mc <= n_mc + {31'h0, mp & ~mc_n};
        {pp, fp, mp} <= {pass_n, fail_n, mc_n};
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask
    // read data stand for the cycle after the strobe; take them at the edge that ends it
    task rdchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        @(posedge clk_i);
        chk(rdata, e);
    endtask
    task mark;
        {b_st, b_ps, b_fl, b_mc} = {n_st, n_ps, n_fl, n_mc};
    endtask
    task deltas(input logic [31:0] s, p, f, m);
        chk(n_st - b_st, s);
        chk(n_ps - b_ps, p);
        chk(n_fl - b_fl, f);
        chk(n_mc - b_mc, m);
    endtask
    // set-up is 20 cycles, then wait (bounded) until all activity is over
    task settle;
        int i;
        repeat (25) @(posedge clk_i);
        for (i = 0; i < 600 && (wl || sl || !mc_n); i++) @(posedge clk_i);
        repeat (20) @(posedge clk_i);
    endtask
    // one-cycle pulse: 0 key, 1 group execute trigger, 2 external fire
    task pulse(input int w);
        {key, get, fire} <= 3'b100 >> w;
        @(posedge clk_i);
        {key, get, fire} <= 3'b000;
    endtask

    task s_regs;
        rdchk(ADDR_CTRL, 32'h0);
        rdchk(ADDR_SCOUNT, 32'h1);
        rdchk(ADDR_TCOUNT, 32'h1);
        rdchk(4'hF, 32'h0);
        wr(ADDR_SCOUNT, 32'h0000_EA60);
        rdchk(ADDR_SCOUNT, 32'h0000_C350);
        wr(ADDR_SCOUNT, 32'h0);
        rdchk(ADDR_SCOUNT, 32'h1);
    endtask
    task s_local;
        mark;
        remote_i <= 1'b0;
        repeat (200) @(posedge clk_i);
        remote_i <= 1'b1;
        settle;
        chk({31'h0, (n_st - b_st) >= 8}, 32'h1);
    endtask
    task s_imm;
        logic [31:0] bad [2];
        bad = '{32'h0000_00C8, 32'h0000_0005};
        wr(ADDR_CTRL, 32'h5);
        wr(ADDR_LOWER, 32'h0000_000A);
        wr(ADDR_UPPER, 32'h0000_0064);
        wr(ADDR_SCOUNT, 32'h3);
        wr(ADDR_TCOUNT, 32'h2);
        mark;
        wr(ADDR_CMD, 32'h1);
        settle;
        deltas(32'h6, 32'h6, 32'h0, 32'h6);
        wr(ADDR_CTRL, 32'h6);
        wr(ADDR_CMD, 32'h2);
        rdchk(ADDR_SCOUNT, 32'h1);
        rdchk(ADDR_CTRL, 32'h5);
        for (int k = 0; k < 2; k++) begin
            val <= bad[k];
            mark;
            wr(ADDR_CMD, 32'h1);
            settle;
            deltas(32'h1, 32'h0, 32'h1, 32'h1);
        end
    endtask
    task s_bus;
        wr(ADDR_CTRL, 32'h2);
        mark;
        wr(ADDR_CMD, 32'h4);
        repeat (30) @(posedge clk_i);
        wr(ADDR_CMD, 32'h1);
        repeat (25) @(posedge clk_i);
        pulse(0);
        repeat (20) @(posedge clk_i);
        deltas(32'h0, 32'h0, 32'h0, 32'h0);
        chk({31'h0, wl}, 32'h1);
        rdchk(ADDR_STAT, 32'h0000_0002);
        wr(ADDR_CMD, 32'h4);
        settle;
        deltas(32'h1, 32'h0, 32'h0, 32'h1);
        wr(ADDR_CMD, 32'h1);
        repeat (25) @(posedge clk_i);
        pulse(1);
        settle;
        deltas(32'h2, 32'h0, 32'h0, 32'h2);
    endtask
    task s_ext;
        wr(ADDR_CTRL, 32'h3);
        wr(ADDR_TCOUNT, 32'h2);
        mark;
        wr(ADDR_CMD, 32'h1);
        pulse(2);
        repeat (30) @(posedge clk_i);
        deltas(32'h0, 32'h0, 32'h0, 32'h0);
        pulse(2);
        repeat (8) @(posedge clk_i);
        pulse(2);
        settle;
        deltas(32'h2, 32'h0, 32'h0, 32'h2);
    endtask
    task s_single;
        remote_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk({31'h0, wl}, 32'h1);
        mark;
        pulse(0);
        repeat (60) @(posedge clk_i);
        pulse(2);
        repeat (60) @(posedge clk_i);
        deltas(32'h2, 32'h0, 32'h0, 32'h2);
        remote_i <= 1'b1;
        wr(ADDR_CMD, 32'h8);
        settle;
    endtask
    task s_clear;
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_SCOUNT, 32'h5);
        mark;
        wr(ADDR_CMD, 32'h1);
        repeat (40) @(posedge clk_i);
        wr(ADDR_CMD, 32'h8);
        settle;
        chk({31'h0, (n_st - b_st) < 5}, 32'h1);
        rdchk(ADDR_SCOUNT, 32'h5);
        rdchk(ADDR_TCOUNT, 32'h2);
        rdchk(ADDR_CTRL, 32'h1);
    endtask
    // 40-cycle delay ahead of each of two readings: start 41 cycles after the trigger
    task s_delay;
        wr(ADDR_CMD, 32'h2);
        wr(ADDR_SCOUNT, 32'h2);
        wr(ADDR_DELAY, 32'h0000_0028);
        rdchk(ADDR_DELAY, 32'h0000_0028);
        mark;
        wr(ADDR_CMD, 32'h1);
        repeat (60) @(posedge clk_i);
        deltas(32'h0, 32'h0, 32'h0, 32'h0);
        repeat (40) @(posedge clk_i);
        deltas(32'h1, 32'h0, 32'h0, 32'h1);
        settle;
        deltas(32'h2, 32'h0, 32'h0, 32'h2);
    endtask

    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence: reset for eight cycles, then every scenario in turn
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        s_regs;
        s_local;
        s_imm;
        s_bus;
        s_ext;
        s_single;
        s_clear;
        s_delay;
        complete_run;
    end
    // watchdog well beyond the few thousand cycles the scenarios need
    initial begin
        #320000;
        failures++;
        complete_run;
    end
endmodule // mts_trig_seq_tb_top
`default_nettype wire
